// File: tws_pkg.sv
package tws_pkg;
  // System clock period in ns
  localparam int TWS_CLK_NS = 40;
  // Longest self-timed write cycle in ns
  localparam int TWS_T_WR_NS = 5000000;
  // Write cycle in clocks, rounded down
  localparam int TWS_WR_CYC = TWS_T_WR_NS / TWS_CLK_NS;
  // Word address width, larger variant
  localparam int TWS_ADDR_W = 15;
  // In-page address bits
  localparam int TWS_PAGE_W = 6;
  // Fixed device code in the address byte
  localparam logic [3:0] TWS_DEV_CODE = 4'hA;
  // Read prefetch depth
  localparam int TWS_FIFO_DEPTH = 8;
  // Synchroniser lanes
  localparam int TWS_PIN_SCL = 0;
  localparam int TWS_PIN_SDA = 1;
  localparam int TWS_PIN_SLO = 2;
  localparam int TWS_PIN_SHI = 3;
  localparam int TWS_PIN_WP = 4;
  // Bus engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK
  } tws_state_t;
endpackage : tws_pkg

// File: tws_fifo.sv
`timescale 1ns/1ps
module tws_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = tws_pkg::TWS_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Drop all content
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  import tws_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  // Pointers and fill level
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
  } tws_fifo_st_t;
  tws_fifo_st_t s;
  tws_fifo_st_t n;
  logic [WIDTH-1:0] store [DEPTH];
  logic push;
  logic pop;

  // Honest full and empty
  assign in_ready_o = (s.cnt != CW'(DEPTH));
  assign out_valid_o = (s.cnt != '0);
  assign out_data_o = store[s.rd];
  assign push = in_valid_i && in_ready_o && !flush_i;
  assign pop = out_valid_o && out_ready_i && !flush_i;

  // Next pointer state
  always_comb
  begin
    n = s;
    if (flush_i)
    begin
      n = '0;
    end
    else
    begin
      if (push)
        n.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + AW'(1);
      if (pop)
        n.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + AW'(1);
      n.cnt = s.cnt + CW'(push) - CW'(pop);
    end
  end

  // State register
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      s <= '0;
    else
      s <= n;
  end

  // Word storage
  always_ff @(posedge core_clk_i)
  begin
    if (push)
      store[s.wr] <= in_data_i;
  end
endmodule : tws_fifo

// File: tws_eeprom_slave.sv
`timescale 1ns/1ps
// What this block does
// - Data changes only while clock low
// - Falling data, clock high: start
// - Rising data, clock high: stop, standby
// - Eight-bit words, ack on ninth clock
// - Sample on rise, drive on fall
// - Ack only when straps match
// - Address LSB one reads, zero writes
// - 14 or 15 bit word address
// - Byte write, stop starts write cycle
// - Busy write cycle ignores bus, no ack
// - Write cycle ends within five ms
// - Page write takes up to 64 bytes
// - Only low six address bits increment
// - Over 64 bytes overwrites same page
// - Ack polling answers after write done
// - Address counter holds last plus one
// - Reads wrap from last to first
// - Current read sends byte at counter
// - Read continues while controller acks
// - Write protect high blocks all writes
module tws_eeprom_slave #(
  parameter int ADDR_W = tws_pkg::TWS_ADDR_W,
  parameter int WR_CYC = tws_pkg::TWS_WR_CYC,
  parameter int FIFO_DEPTH = tws_pkg::TWS_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Two-wire bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // Straps and protect
  input wire logic strap_select_low_i,
  input wire logic strap_select_high_i,
  input wire logic write_protect_i,
  // Status
  output logic standby_o,
  output logic write_busy_o
);
  import tws_pkg::*;
  localparam int TW = $clog2(WR_CYC + 1);
  localparam int PN = 2 ** TWS_PAGE_W;
  localparam int PW = TWS_PAGE_W;
  localparam int RW = ADDR_W - PW;

  // Whole state of the block
  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic scl_q;
    logic sda_q;
    tws_state_t state;
    logic [3:0] bitcnt;
    logic [1:0] byte_idx;
    logic rw;
    logic ack_in;
    logic [7:0] shift;
    logic [ADDR_W-1:0] addr_cnt;
    logic [ADDR_W-1:0] fetch;
    logic [RW-1:0] wpage;
    logic [PN-1:0] pvalid;
    logic wr_pend;
    logic busy;
    logic [PW:0] cidx;
    logic [TW-1:0] timer;
    logic sda_oen;
  } tws_core_t;

  tws_core_t s;
  tws_core_t n;
  // Array and page latch
  logic [7:0] mem [2**ADDR_W];
  logic [7:0] pbuf [PN];
  // Synchronised pins
  logic scl_s;
  logic sda_s;
  logic wp_s;
  // Bus events
  logic rise_e;
  logic fall_e;
  logic start_e;
  logic stop_e;
  // Memory side strobes
  logic pb_we;
  logic mem_we;
  logic do_load;
  logic pop;
  logic flush;
  logic f_in_valid;
  logic f_in_ready;
  logic f_out_valid;
  logic [7:0] f_out_data;

  // Address byte match against straps
  function automatic logic dev_ok(input logic [7:0] b, input logic [4:0] p);
    dev_ok = (b[7:4] == TWS_DEV_CODE) && !b[3]
      && (b[2:1] == {p[TWS_PIN_SHI], p[TWS_PIN_SLO]});
  endfunction : dev_ok

  // Second stage feeds logic only
  assign scl_s = s.sync2[TWS_PIN_SCL];
  assign sda_s = s.sync2[TWS_PIN_SDA];
  assign wp_s = s.sync2[TWS_PIN_WP];
  assign rise_e = scl_s && !s.scl_q;
  assign fall_e = !scl_s && s.scl_q;
  assign start_e = scl_s && s.scl_q && s.sda_q && !sda_s;
  assign stop_e = scl_s && s.scl_q && !s.sda_q && sda_s;

  // Open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_n_o = s.sda_oen;
  assign standby_o = (s.state == ST_IDLE) && !s.busy;
  assign write_busy_o = s.busy;
  // Prefetch stalls while writing or flushing
  assign f_in_valid = !s.busy && !flush;

  // Next state
  always_comb
  begin
    n = s;
    pb_we = 1'b0;
    mem_we = 1'b0;
    do_load = 1'b0;
    pop = 1'b0;
    flush = 1'b0;
    n.sync1 = {write_protect_i, strap_select_high_i, strap_select_low_i, sda_i, scl_i};
    n.sync2 = s.sync1;
    n.scl_q = scl_s;
    n.sda_q = sda_s;
    // Self-timed write cycle
    if (s.busy)
    begin
      if (s.cidx < (PW+1)'(PN))
      begin
        mem_we = s.pvalid[s.cidx[PW-1:0]];
        n.cidx = s.cidx + (PW+1)'(1);
      end
      if (s.timer == TW'(WR_CYC - 1))
      begin
        n.busy = 1'b0;
        n.pvalid = '0;
      end
      else
        n.timer = s.timer + TW'(1);
    end
    if (start_e)
    begin
      n.state = ST_RX;
      n.bitcnt = '0;
      n.byte_idx = '0;
      n.sda_oen = 1'b1;
      flush = 1'b1;
      if (!s.busy)
      begin
        n.wr_pend = 1'b0;
        n.pvalid = '0;
      end
    end
    else if (stop_e)
    begin
      n.state = ST_IDLE;
      n.sda_oen = 1'b1;
      flush = 1'b1;
      n.wr_pend = 1'b0;
      if (s.wr_pend && !s.busy)
      begin
        if (wp_s)
          n.pvalid = '0;
        else
        begin
          n.busy = 1'b1;
          n.timer = '0;
          n.cidx = '0;
        end
      end
    end
    else
    begin
      case (s.state)
        ST_RX:
        begin
          if (rise_e)
          begin
            n.shift = {s.shift[6:0], sda_s};
            n.bitcnt = s.bitcnt + 4'h1;
          end
          else if (fall_e && (s.bitcnt == 4'h8))
          begin
            if (s.byte_idx == 2'h0)
            begin
              if (dev_ok(s.shift, s.sync2) && !s.busy)
              begin
                n.rw = s.shift[0];
                n.state = ST_RX_ACK;
                n.sda_oen = 1'b0;
              end
              else
                n.state = ST_IDLE;
            end
            else
            begin
              n.state = ST_RX_ACK;
              n.sda_oen = 1'b0;
              if (s.byte_idx == 2'h1)
              begin
                n.addr_cnt[ADDR_W-1:8] = s.shift[ADDR_W-9:0];
              end
              else if (s.byte_idx == 2'h2)
              begin
                n.addr_cnt[7:0] = s.shift;
                n.wpage = n.addr_cnt[ADDR_W-1:PW];
                flush = 1'b1;
              end
              else
              begin
                pb_we = 1'b1;
                n.pvalid[s.addr_cnt[PW-1:0]] = 1'b1;
                n.wr_pend = 1'b1;
                n.addr_cnt[PW-1:0] = s.addr_cnt[PW-1:0] + PW'(1);
              end
            end
          end
        end
        ST_RX_ACK:
        begin
          // Release after ninth clock, or drive first bit of a read
          if (fall_e)
          begin
            n.sda_oen = 1'b1;
            n.bitcnt = '0;
            n.byte_idx = (s.byte_idx == 2'h3) ? 2'h3 : s.byte_idx + 2'h1;
            if (s.rw)
              do_load = 1'b1;
            else
              n.state = ST_RX;
          end
        end
        ST_TX:
        begin
          if (rise_e)
            n.bitcnt = s.bitcnt + 4'h1;
          else if (fall_e)
          begin
            if (s.bitcnt == 4'h8)
            begin
              n.sda_oen = 1'b1;
              n.ack_in = 1'b0;
              n.state = ST_TX_ACK;
            end
            else
            begin
              n.shift = {s.shift[6:0], 1'b1};
              n.sda_oen = s.shift[6];
            end
          end
        end
        ST_TX_ACK:
        begin
          if (rise_e)
          begin
            if (sda_s)
              n.state = ST_IDLE;
            else
              n.ack_in = 1'b1;
          end
          else if (fall_e && s.ack_in)
            do_load = 1'b1;
        end
        default:
        begin
          n.state = ST_IDLE;
        end
      endcase
    end
    if (do_load)
    begin
      n.state = ST_TX;
      // Fresh bit count for every byte sent
      n.bitcnt = '0;
      n.ack_in = 1'b0;
      n.shift = f_out_valid ? f_out_data : 8'hFF;
      n.sda_oen = n.shift[7];
      if (f_out_valid)
      begin
        pop = 1'b1;
        n.addr_cnt = s.addr_cnt + ADDR_W'(1);
      end
    end
    // Prefetch pointer follows counter
    if (flush)
      n.fetch = n.addr_cnt;
    else if (f_in_valid && f_in_ready)
      n.fetch = s.fetch + ADDR_W'(1);
  end

  // State register
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s <= '0;
      s.sda_oen <= 1'b1;
    end
    else
      s <= n;
  end

  // Page latch and array writes
  always_ff @(posedge core_clk_i)
  begin
    if (pb_we)
      pbuf[s.addr_cnt[PW-1:0]] <= s.shift;
    if (mem_we)
      mem[{s.wpage, s.cidx[PW-1:0]}] <= pbuf[s.cidx[PW-1:0]];
  end

  // Read prefetch queue
  tws_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_prefetch (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .flush_i(flush),
    .in_valid_i(f_in_valid),
    .in_ready_o(f_in_ready),
    .in_data_i(mem[s.fetch]),
    .out_valid_o(f_out_valid),
    .out_ready_i(pop),
    .out_data_o(f_out_data)
  );

  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_quiet;
    !start_e && !stop_e;
  endsequence
  sequence s_dev_done;
    s.state == ST_RX && s.byte_idx == 2'h0 && s.bitcnt == 4'h8 && fall_e ##0 s_quiet;
  endsequence
  sequence s_data_done;
    s.state == ST_RX && s.byte_idx == 2'h3 && s.bitcnt == 4'h8 && fall_e ##0 s_quiet;
  endsequence

  property p_nomatch;
    s_dev_done ##0 !dev_ok(s.shift, s.sync2) |=> s.state == ST_IDLE && s.sda_oen;
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("ack on address mismatch");
  property p_busy_quiet;
    s.busy |-> s.sda_oen;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("bus driven while busy");
  property p_wr_len;
    $fell(s.busy) |-> $past(s.timer) == TW'(WR_CYC - 1);
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write cycle length wrong");
  property p_start;
    start_e |=> s.state == ST_RX && s.bitcnt == 4'h0 && s.byte_idx == 2'h0;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_stop;
    stop_e && !s.wr_pend && !s.busy |=> standby_o;
  endproperty
  a_stop: assert property (p_stop) else $error("no standby after stop");
  property p_drive_edge;
    $changed(s.sda_oen) |-> $past(fall_e || start_e || stop_e);
  endproperty
  a_drive_edge: assert property (p_drive_edge) else $error("data moved off falling edge");
  property p_ack_hold;
    s.state == ST_RX_ACK |-> !s.sda_oen;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack not held low");
  property p_page_inc;
    s_data_done |=> s.addr_cnt[ADDR_W-1:PW] == $past(s.addr_cnt[ADDR_W-1:PW])
      && s.addr_cnt[PW-1:0] == $past(s.addr_cnt[PW-1:0]) + PW'(1);
  endproperty
  a_page_inc: assert property (p_page_inc) else $error("page address step wrong");
  property p_protect;
    stop_e && wp_s && !s.busy |=> !s.busy;
  endproperty
  a_protect: assert property (p_protect) else $error("write under protect");
  property p_nack_end;
    s.state == ST_TX_ACK && rise_e && sda_s ##0 s_quiet |=> s.state == ST_IDLE;
  endproperty
  a_nack_end: assert property (p_nack_end) else $error("read went on after nack");
  property p_rd_wrap;
    pop && s.addr_cnt == '1 |=> s.addr_cnt == '0;
  endproperty
  a_rd_wrap: assert property (p_rd_wrap) else $error("read address did not wrap");
endmodule : tws_eeprom_slave

// File: tws_ctl_model.sv
`timescale 1ns/1ps
// Bus controller on the far side of the two-wire pins
module tws_ctl_model (
  // Clock
  input wire logic clk_i,
  // Bus pins
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  // Idle bus, both lines high, clock stands still
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Wait whole core clocks
  task automatic w(input int n);
    repeat (n) @(negedge clk_i);
  endtask : w
  task automatic bit_x(input logic v, output logic s);
    sda_o = v;
    w(2);
    scl_o = 1'b1;
    w(2);
    s = sda_i;
    w(2);
    scl_o = 1'b0;
    w(2);
  endtask : bit_x
  task automatic start();
    sda_o = 1'b1;
    w(2);
    scl_o = 1'b1;
    w(2);
    sda_o = 1'b0;
    w(2);
    scl_o = 1'b0;
    w(2);
  endtask : start
  task automatic stop();
    sda_o = 1'b0;
    w(2);
    scl_o = 1'b1;
    w(2);
    sda_o = 1'b1;
    w(4);
  endtask : stop
  // eight bits, top bit first, ack read on ninth
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(b[i], s);
    end
    bit_x(1'b1, ack);
  endtask : wr_byte
  // line released, then own ack or nack
  task automatic rd_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(1'b1, b[i]);
    end
    bit_x(nack, s);
  endtask : rd_byte
endmodule : tws_ctl_model

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import tws_pkg::*;
  // Shortened write cycle
  localparam int WR_CYC = 200;
  // Address byte for straps high=1, low=0
  localparam logic [7:0] DEV_W = 8'hA4;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic scl, ctl_sda, sda_w, sda_o, sda_oe_n_o, wp;
  logic standby_o, write_busy_o;
  int num_errors = 0;
  int check_count = 0;
  int busy_cnt = 0;
  // Reference array
  logic [7:0] mem [0:32767];
  // 25 MHz core clock
  always #20 core_clk_i = ~core_clk_i;
  // Wired-AND data line with pull-up
  assign sda_w = ctl_sda & (sda_oe_n_o | sda_o);
  // Busy length counter
  always @(posedge core_clk_i)
  begin
    if (write_busy_o)
      busy_cnt <= busy_cnt + 1;
  end
  tws_eeprom_slave #(.WR_CYC(WR_CYC)) i_dut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .strap_select_low_i(1'b0), .strap_select_high_i(1'b1),
    .write_protect_i(wp), .standby_o(standby_o), .write_busy_o(write_busy_o));
  tws_ctl_model i_ctl (.clk_i(core_clk_i), .scl_o(scl), .sda_o(ctl_sda), .sda_i(sda_w));
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Verdict and end of run
  task automatic test_done();
    $display("Errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  // Bounded wait for busy level
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (write_busy_o !== v)
    begin
      @(negedge core_clk_i);
      n++;
      if (n > 400)
      begin
        num_errors++;
        test_done();
      end
    end
  endtask : wait_busy
  // Start, device byte, two word-address bytes
  task automatic addr_phase(input logic [14:0] a);
    logic ack;
    i_ctl.start();
    i_ctl.wr_byte(DEV_W, ack);
    chk(16'(ack), 16'h0);
    i_ctl.wr_byte({1'b0, a[14:8]}, ack);
    chk(16'(ack), 16'h0);
    i_ctl.wr_byte(a[7:0], ack);
    chk(16'(ack), 16'h0);
  endtask : addr_phase
  // Foreign address bytes get no ack
  task automatic t_mismatch();
    logic ack;
    logic [7:0] bad [4] = '{8'hA6, 8'hA0, 8'hAC, 8'h24};
    for (int i = 0; i < 4; i++)
    begin
      i_ctl.start();
      i_ctl.wr_byte(bad[i], ack);
      chk(16'(ack), 16'h1);
      i_ctl.stop();
    end
  endtask : t_mismatch
  // Byte or page write, then busy and polling; under protect, busy must stay low
  task automatic t_write(input logic [14:0] a, input int n, input logic p, input logic [7:0] d0);
    logic ack;
    logic [7:0] d;
    wp = p;
    addr_phase(a);
    for (int i = 0; i < n; i++)
    begin
      if (!p)
        mem[{a[14:6], 6'(a[5:0] + i)}] = 8'(d0 + i);
      i_ctl.wr_byte(8'(d0 + i), ack);
      chk(16'(ack), 16'h0);
    end
    busy_cnt = 0;
    i_ctl.stop();
    if (p)
    begin
      i_ctl.w(20);
      chk(16'(write_busy_o), 16'h0);
    end
    else
    begin
      wait_busy(1'b1);
      chk(16'(standby_o), 16'h0);
      i_ctl.start();
      i_ctl.wr_byte(DEV_W, ack);
      chk(16'(ack), 16'h1);
      i_ctl.stop();
      wait_busy(1'b0);
      chk(16'(busy_cnt), 16'(WR_CYC));
      chk(16'(standby_o), 16'h1);
      i_ctl.start();
      i_ctl.wr_byte(DEV_W | 8'h01, ack);
      chk(16'(ack), 16'h0);
      i_ctl.rd_byte(1'b1, d);
      i_ctl.stop();
    end
    wp = 1'b0;
  endtask : t_write
  // Random or current read of n bytes
  task automatic t_read(input logic cur, input logic [14:0] a, input int n);
    logic ack;
    logic [7:0] d;
    if (!cur)
      addr_phase(a);
    i_ctl.start();
    i_ctl.wr_byte(DEV_W | 8'h01, ack);
    chk(16'(ack), 16'h0);
    for (int i = 0; i < n; i++)
    begin
      i_ctl.rd_byte(i == n - 1, d);
      chk(16'(d), 16'(mem[15'(a + i)]));
    end
    i_ctl.stop();
    i_ctl.w(4);
    chk(16'(standby_o), 16'h1);
  endtask : t_read
  // Main sequence
  initial
  begin
    wp = 1'b0;
    repeat (6) @(negedge core_clk_i);
    chk(16'(standby_o), 16'h1);
    chk(16'(sda_oe_n_o), 16'h1);
    sys_rst_i = 1'b0;
    repeat (6) @(negedge core_clk_i);
    t_mismatch();
    t_write(15'h0100, 1, 1'b0, 8'h11);
    t_read(1'b0, 15'h0100, 1);
    t_write(15'h013E, 66, 1'b0, 8'h40);
    t_read(1'b0, 15'h0100, 64);
    t_write(15'h7FFF, 1, 1'b0, 8'hC3);
    t_write(15'h0000, 1, 1'b0, 8'h3C);
    t_read(1'b0, 15'h7FFF, 2);
    t_write(15'h0100, 1, 1'b1, 8'hEE);
    t_read(1'b0, 15'h0100, 1);
    t_read(1'b1, 15'h0101, 1);
    test_done();
  end
endmodule : tb_top
